// ===== rtl/subgroup_decode_pkg.sv
// package: field positions, subgroup selectors and decoded operation identifiers
package subgroup_decode_pkg;

    // instruction field positions
    localparam int ROTATE_BIT      = 21;
    localparam int MISC_SPLIT_BIT  = 5;
    localparam int SHAMT_HI        = 10;
    localparam int SHAMT_LO        = 6;
    localparam int SRC_REG_HI      = 25;
    localparam int SRC_REG_LO      = 21;
    localparam int FUNC_HI         = 5;
    localparam int FUNC_LO         = 0;
    localparam int PC_MINOR_HI     = 20;
    localparam int PC_MINOR_LO     = 16;

    // reset values of the output registers
    localparam logic RESET_VALID    = 1'h0;
    localparam logic RESET_RESERVED = 1'h0;

    // which secondary map the fetch stage asks for
    typedef enum logic [2:0] {
        GRP_DWORD_SHIFT_RIGHT,
        GRP_DWORD_SHIFT_RIGHT_PLUS32,
        GRP_WORD_SHUFFLE,
        GRP_DWORD_SHUFFLE,
        GRP_SYSCTL,
        GRP_PC_RELATIVE,
        GRP_FPU,
        GRP_NONE
    } group_e;

    // decoded operation identifiers
    typedef enum logic [5:0] {
        OP_NONE,
        OP_DWORD_SHIFT_RIGHT_LOGICAL, OP_DWORD_ROTATE_RIGHT,
        OP_DWORD_SHIFT_RIGHT_LOGICAL_PLUS32, OP_DWORD_ROTATE_RIGHT_PLUS32,
        OP_BYTE_BIT_REVERSE, OP_DWORD_BYTE_BIT_REVERSE,
        OP_HALFWORD_BYTE_SWAP, OP_DWORD_HALFWORD_BYTE_SWAP, OP_DWORD_HALFWORD_SWAP,
        OP_WORD_BYTE_CONCAT, OP_DWORD_BYTE_CONCAT,
        OP_SIGN_EXTEND_BYTE, OP_SIGN_EXTEND_HALF,
        OP_SYSCTL_MOVE_FROM, OP_SYSCTL_DWORD_MOVE_FROM, OP_SYSCTL_HIGH_MOVE_FROM,
        OP_SYSCTL_MOVE_TO, OP_SYSCTL_DWORD_MOVE_TO, OP_SYSCTL_HIGH_MOVE_TO,
        OP_PREV_SHADOW_READ, OP_PREV_SHADOW_WRITE, OP_INTR_DISABLE, OP_INTR_ENABLE,
        OP_TRANSLATION_ENTRY_READ, OP_TRANSLATION_WRITE_INDEXED,
        OP_TRANSLATION_INVALIDATE, OP_TRANSLATION_INVALIDATE_FLUSH,
        OP_TRANSLATION_WRITE_RANDOM, OP_TRANSLATION_PROBE,
        OP_EXCEPTION_RETURN, OP_DEBUG_EXCEPTION_RETURN, OP_WAIT,
        OP_PC_ADD_IMM, OP_PC_LOAD_WORD, OP_PC_LOAD_WORD_UNSIGNED, OP_PC_LOAD_DWORD,
        OP_PC_ADD_UPPER, OP_PC_ADD_UPPER_ALIGNED,
        OP_FPU_MOVE_FROM, OP_FPU_DWORD_MOVE_FROM, OP_FPU_CTRL_MOVE_FROM,
        OP_FPU_HIGH_MOVE_FROM, OP_FPU_MOVE_TO, OP_FPU_DWORD_MOVE_TO,
        OP_FPU_CTRL_MOVE_TO, OP_FPU_HIGH_MOVE_TO,
        OP_FPU_BRANCH_COND_ZERO, OP_FPU_BRANCH_COND_NONZERO,
        OP_VECTOR_BRANCH_ALL_ZERO, OP_VECTOR_BRANCH_ANY_NONZERO,
        OP_VECTOR_ELEM_ZERO, OP_VECTOR_ELEM_NONZERO,
        OP_FMT_SINGLE, OP_FMT_DOUBLE, OP_FMT_WORD, OP_FMT_LONG, OP_PAIRED_SINGLE_FMT
    } op_e;

endpackage

// ===== rtl/subgroup_decoder.sv
// secondary-opcode decoder for the shift, shuffle, system, pc-relative and fpu maps
//
// Function
// - dword shift right: bit 21 picks rotate
// - shift right plus32: bit 21 picks rotate
// - compat mode ignores bit 21, always shift
// - shuffle selector: reverse, byte swap, halfword swap
// - shuffle: concat, sign-extend byte, sign-extend half
// - unassigned shuffle selectors are reserved
// - system source field move-from/move-to decode
// - shadow read/write, misc group, op group
// - misc group: bit 5 disable or enable
// - op group function field decode
// - pc-relative minor opcode decode
// - fpu source field move decode
// - fpu source field format decode
`timescale 1ns/1ps
`default_nettype none

module subgroup_decoder
    import subgroup_decode_pkg::*;
(
    // clock and reset
    input  wire logic                         clk_in,
    input  wire logic                         reset_in,
    // request from fetch
    input  wire logic                         instr_valid_in,
    input  wire logic [31:0]                  instr_in,
    input  wire subgroup_decode_pkg::group_e  group_in,
    input  wire logic                         compat_release1_in,
    // answer to execute
    output logic                              valid_out,
    output subgroup_decode_pkg::op_e          op_out,
    output logic                              reserved_out
);
    import subgroup_decode_pkg::*;

    logic valid_reg;
    logic valid_next;
    logic reserved_reg;
    logic reserved_next;
    op_e  op_reg;
    op_e  op_next;

    // field views of the instruction word
    logic [4:0] shamt;
    logic [4:0] src_reg;
    logic [5:0] func;
    logic [4:0] minor;
    assign shamt   = instr_in[SHAMT_HI:SHAMT_LO];
    assign src_reg = instr_in[SRC_REG_HI:SRC_REG_LO];
    assign func    = instr_in[FUNC_HI:FUNC_LO];
    assign minor   = instr_in[PC_MINOR_HI:PC_MINOR_LO];

    // decode; anything unmatched stays OP_NONE and is flagged reserved
    always_comb begin
        op_e  op;
        logic rot;
        op  = OP_NONE;
        rot = instr_in[ROTATE_BIT] && !compat_release1_in;
        case (group_in)
            GRP_DWORD_SHIFT_RIGHT: begin
                op = rot ? OP_DWORD_ROTATE_RIGHT : OP_DWORD_SHIFT_RIGHT_LOGICAL;
            end
            GRP_DWORD_SHIFT_RIGHT_PLUS32: begin
                op = rot ? OP_DWORD_ROTATE_RIGHT_PLUS32
                         : OP_DWORD_SHIFT_RIGHT_LOGICAL_PLUS32;
            end
            GRP_WORD_SHUFFLE, GRP_DWORD_SHUFFLE: begin
                // sparse decode: only listed selectors map, the rest are trapped
                case (shamt) inside
                    5'h00: begin
                        op = (group_in == GRP_DWORD_SHUFFLE) ? OP_DWORD_BYTE_BIT_REVERSE
                                                             : OP_BYTE_BIT_REVERSE;
                    end
                    5'h02: begin
                        op = (group_in == GRP_DWORD_SHUFFLE) ? OP_DWORD_HALFWORD_BYTE_SWAP
                                                             : OP_HALFWORD_BYTE_SWAP;
                    end
                    5'h05: begin
                        if (group_in == GRP_DWORD_SHUFFLE) begin
                            op = OP_DWORD_HALFWORD_SWAP;
                        end
                    end
                    [5'h08:5'h0F]: begin
                        op = (group_in == GRP_DWORD_SHUFFLE) ? OP_DWORD_BYTE_CONCAT
                                                             : OP_WORD_BYTE_CONCAT;
                    end
                    // sign extension has no doubleword form, so there it traps
                    5'h10: begin
                        if (group_in == GRP_WORD_SHUFFLE) begin
                            op = OP_SIGN_EXTEND_BYTE;
                        end
                    end
                    5'h18: begin
                        if (group_in == GRP_WORD_SHUFFLE) begin
                            op = OP_SIGN_EXTEND_HALF;
                        end
                    end
                    default: op = OP_NONE;
                endcase
            end
            GRP_SYSCTL: begin
                if (src_reg[4]) begin
                    case (func)
                        6'h01: op = OP_TRANSLATION_ENTRY_READ;
                        6'h02: op = OP_TRANSLATION_WRITE_INDEXED;
                        6'h03: op = OP_TRANSLATION_INVALIDATE;
                        6'h04: op = OP_TRANSLATION_INVALIDATE_FLUSH;
                        6'h06: op = OP_TRANSLATION_WRITE_RANDOM;
                        6'h08: op = OP_TRANSLATION_PROBE;
                        6'h18: op = OP_EXCEPTION_RETURN;
                        6'h1F: op = OP_DEBUG_EXCEPTION_RETURN;
                        6'h20: op = OP_WAIT;
                        default: op = OP_NONE;
                    endcase
                end else begin
                    case (src_reg)
                        5'h00: op = OP_SYSCTL_MOVE_FROM;
                        5'h01: op = OP_SYSCTL_DWORD_MOVE_FROM;
                        5'h02: op = OP_SYSCTL_HIGH_MOVE_FROM;
                        5'h04: op = OP_SYSCTL_MOVE_TO;
                        5'h05: op = OP_SYSCTL_DWORD_MOVE_TO;
                        5'h06: op = OP_SYSCTL_HIGH_MOVE_TO;
                        5'h0A: op = OP_PREV_SHADOW_READ;
                        5'h0E: op = OP_PREV_SHADOW_WRITE;
                        5'h0B: begin
                            op = instr_in[MISC_SPLIT_BIT] ? OP_INTR_ENABLE
                                                          : OP_INTR_DISABLE;
                        end
                        default: op = OP_NONE;
                    endcase
                end
            end
            GRP_PC_RELATIVE: begin
                // low minor bits are immediate payload except in the 111 column
                case (minor[4:3])
                    2'h0: op = OP_PC_ADD_IMM;
                    2'h1: op = OP_PC_LOAD_WORD;
                    2'h2: op = OP_PC_LOAD_WORD_UNSIGNED;
                    default: begin
                        if (!minor[2]) begin
                            op = OP_PC_LOAD_DWORD;
                        end else if (minor[1:0] == 2'h2) begin
                            op = OP_PC_ADD_UPPER;
                        end else if (minor[1:0] == 2'h3) begin
                            op = OP_PC_ADD_UPPER_ALIGNED;
                        end
                    end
                endcase
            end
            GRP_FPU: begin
                case (src_reg) inside
                    5'h00: op = OP_FPU_MOVE_FROM;
                    5'h01: op = OP_FPU_DWORD_MOVE_FROM;
                    5'h02: op = OP_FPU_CTRL_MOVE_FROM;
                    5'h03: op = OP_FPU_HIGH_MOVE_FROM;
                    5'h04: op = OP_FPU_MOVE_TO;
                    5'h05: op = OP_FPU_DWORD_MOVE_TO;
                    5'h06: op = OP_FPU_CTRL_MOVE_TO;
                    5'h07: op = OP_FPU_HIGH_MOVE_TO;
                    5'h09: op = OP_FPU_BRANCH_COND_ZERO;
                    5'h0D: op = OP_FPU_BRANCH_COND_NONZERO;
                    5'h0B: op = OP_VECTOR_BRANCH_ALL_ZERO;
                    5'h0F: op = OP_VECTOR_BRANCH_ANY_NONZERO;
                    [5'h18:5'h1B]: op = OP_VECTOR_ELEM_ZERO;
                    [5'h1C:5'h1F]: op = OP_VECTOR_ELEM_NONZERO;
                    5'h10: op = OP_FMT_SINGLE;
                    5'h11: op = OP_FMT_DOUBLE;
                    5'h14: op = OP_FMT_WORD;
                    5'h15: op = OP_FMT_LONG;
                    5'h16: op = OP_PAIRED_SINGLE_FMT;
                    default: op = OP_NONE;
                endcase
            end
            default: op = OP_NONE;
        endcase
        valid_next    = instr_valid_in;
        op_next       = instr_valid_in ? op : OP_NONE;
        reserved_next = instr_valid_in && (op == OP_NONE);
    end

    // one pipeline register so execute sees stable flopped data
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            valid_reg    <= RESET_VALID;
            op_reg       <= OP_NONE;
            reserved_reg <= RESET_RESERVED;
        end else begin
            valid_reg    <= valid_next;
            op_reg       <= op_next;
            reserved_reg <= reserved_next;
        end
    end

    assign valid_out    = valid_reg;
    assign op_out       = op_reg;
    assign reserved_out = reserved_reg;

    // checks on the registered answer
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    shift_rotate_a: assert property (instr_valid_in
        && group_in == GRP_DWORD_SHIFT_RIGHT
        && !compat_release1_in |=> op_out == (($past(instr_in[ROTATE_BIT]))
        ? OP_DWORD_ROTATE_RIGHT : OP_DWORD_SHIFT_RIGHT_LOGICAL))
        else $error("shift right rotate select wrong");
    plus32_rotate_a: assert property (instr_valid_in
        && group_in == GRP_DWORD_SHIFT_RIGHT_PLUS32
        && !compat_release1_in && instr_in[ROTATE_BIT]
        |=> op_out == OP_DWORD_ROTATE_RIGHT_PLUS32)
        else $error("plus32 rotate not selected");
    compat_shift_a: assert property (instr_valid_in && compat_release1_in
        && (group_in == GRP_DWORD_SHIFT_RIGHT || group_in == GRP_DWORD_SHIFT_RIGHT_PLUS32)
        |=> op_out inside {OP_DWORD_SHIFT_RIGHT_LOGICAL, OP_DWORD_SHIFT_RIGHT_LOGICAL_PLUS32})
        else $error("compat mode produced a rotate");
    half_swap_a: assert property (instr_valid_in && shamt == 5'h05
        && (group_in == GRP_WORD_SHUFFLE || group_in == GRP_DWORD_SHUFFLE)
        |=> op_out == (($past(group_in) == GRP_DWORD_SHUFFLE)
        ? OP_DWORD_HALFWORD_SWAP : OP_NONE)
        && reserved_out == ($past(group_in) == GRP_WORD_SHUFFLE))
        else $error("halfword swap group check failed");
    sign_half_a: assert property (instr_valid_in && group_in == GRP_WORD_SHUFFLE
        && shamt == 5'h18 |=> valid_out && op_out == OP_SIGN_EXTEND_HALF)
        else $error("sign-extend half not decoded");
    misc_split_a: assert property (instr_valid_in && group_in == GRP_SYSCTL
        && src_reg == 5'h0B ##1 valid_out |-> op_out == ($past(instr_in[MISC_SPLIT_BIT])
        ? OP_INTR_ENABLE : OP_INTR_DISABLE))
        else $error("misc group split wrong");
    pc_upper_a: assert property (instr_valid_in && group_in == GRP_PC_RELATIVE
        && minor[4:2] == 3'h7 && !minor[1] |=> reserved_out && op_out == OP_NONE)
        else $error("pc-relative reserved row decoded");
    fpu_move_a: assert property (instr_valid_in && group_in == GRP_FPU
        && src_reg == 5'h06 |=> op_out == OP_FPU_CTRL_MOVE_TO && !reserved_out)
        else $error("fpu control move-to wrong");
    reserved_idle_a: assert property (!instr_valid_in
        |=> !valid_out && !reserved_out && op_out == OP_NONE)
        else $error("answer without request");

endmodule

`default_nettype wire

// ===== tb/exec_stage_model.sv
// execute-stage model: takes every decoded answer and tallies it by kind
`timescale 1ns/1ps
`default_nettype none
module exec_stage_model
    import subgroup_decode_pkg::*;
(
    // clock and reset
    input  wire logic                      clk_in,
    input  wire logic                      reset_in,
    // answer from the decoder
    input  wire logic                      valid_in,
    input  wire subgroup_decode_pkg::op_e  op_in,
    input  wire logic                      reserved_in,
    // tallies read by the bench
    output logic [15:0]                    taken_out,
    output logic [15:0]                    trapped_out
);
    import subgroup_decode_pkg::*;

    // reserved answers go to the exception path, never to execute
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            taken_out   <= 16'h0000;
            trapped_out <= 16'h0000;
        end else if (valid_in && reserved_in) begin
            trapped_out <= trapped_out + 16'h0001;
        end else if (valid_in && op_in != OP_NONE) begin
            taken_out <= taken_out + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// ===== tb/subgroup_decoder_tb.sv
// directed testbench for the subgroup decoder, one task per subgroup map
`timescale 1ns/1ps
`default_nettype none
module subgroup_decoder_tb;
    import subgroup_decode_pkg::*;
    logic        clk_in;
    logic        reset_in;
    logic        instr_valid_in;
    logic [31:0] instr_in;
    group_e      group_in;
    logic        compat_release1_in;
    logic        valid_out;
    op_e         op_out;
    logic        reserved_out;
    logic [15:0] taken;
    logic [15:0] trapped;
    int          exp_taken;
    int          exp_trapped;
    int          errors;
    int          samples_checked;

    subgroup_decoder subgroup_decoder_inst (.clk_in(clk_in), .reset_in(reset_in),
        .instr_valid_in(instr_valid_in), .instr_in(instr_in), .group_in(group_in),
        .compat_release1_in(compat_release1_in), .valid_out(valid_out), .op_out(op_out),
        .reserved_out(reserved_out));
    exec_stage_model exec_stage_model_inst (.clk_in(clk_in), .reset_in(reset_in),
        .valid_in(valid_out), .op_in(op_out), .reserved_in(reserved_out),
        .taken_out(taken), .trapped_out(trapped));

    // field builders: shift amount, source reg plus function, pc-relative minor
    function automatic logic [31:0] shamt_word(input logic [4:0] v);
        return {21'h000000, v, 6'h00};
    endfunction
    function automatic logic [31:0] rsf(input logic [4:0] v, input logic [5:0] f);
        return {6'h00, v, 15'h0000, f};
    endfunction
    function automatic logic [31:0] pcr(input logic [4:0] v);
        return {11'h000, v, 16'h0000};
    endfunction

    task automatic finish_test;
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // valid is left high so the next call runs back to back; OP_NONE means reserved
    task automatic req(input group_e g, input logic [31:0] w, input op_e e,
                       input logic c = 1'b0);
        instr_valid_in     = 1'b1;
        group_in           = g;
        instr_in           = w;
        compat_release1_in = c;
        @(posedge clk_in);
        #1;
        cmp(16'(valid_out), 16'h0001);
        cmp(16'(op_out), 16'(e));
        cmp(16'(reserved_out), 16'(e == OP_NONE));
        if (e == OP_NONE) exp_trapped++;
        else exp_taken++;
    endtask

    // answers stand one cycle only
    task automatic idle;
        instr_valid_in = 1'b0;
        @(posedge clk_in);
        #1;
        cmp(16'(valid_out), 16'h0000);
        cmp(16'(op_out), 16'(OP_NONE));
        cmp(16'(reserved_out), 16'h0000);
    endtask

    task automatic t_shift;
        req(GRP_DWORD_SHIFT_RIGHT, 32'h0000_0000, OP_DWORD_SHIFT_RIGHT_LOGICAL);
        req(GRP_DWORD_SHIFT_RIGHT, 32'h0020_0000, OP_DWORD_ROTATE_RIGHT);
        req(GRP_DWORD_SHIFT_RIGHT_PLUS32, 32'hFFDF_FFFF,
            OP_DWORD_SHIFT_RIGHT_LOGICAL_PLUS32);
        req(GRP_DWORD_SHIFT_RIGHT_PLUS32, 32'h0020_0000,
            OP_DWORD_ROTATE_RIGHT_PLUS32);
        req(GRP_DWORD_SHIFT_RIGHT, 32'h0020_0000,
            OP_DWORD_SHIFT_RIGHT_LOGICAL, 1'b1);
        req(GRP_DWORD_SHIFT_RIGHT_PLUS32, 32'hFFFF_FFFF,
            OP_DWORD_SHIFT_RIGHT_LOGICAL_PLUS32, 1'b1);
        idle();
    endtask

    task automatic t_shuffle;
        req(GRP_WORD_SHUFFLE, shamt_word(5'h00), OP_BYTE_BIT_REVERSE);
        req(GRP_DWORD_SHUFFLE, shamt_word(5'h00), OP_DWORD_BYTE_BIT_REVERSE);
        req(GRP_WORD_SHUFFLE, shamt_word(5'h02), OP_HALFWORD_BYTE_SWAP);
        req(GRP_DWORD_SHUFFLE, shamt_word(5'h02), OP_DWORD_HALFWORD_BYTE_SWAP);
        req(GRP_DWORD_SHUFFLE, shamt_word(5'h05), OP_DWORD_HALFWORD_SWAP);
        req(GRP_WORD_SHUFFLE, shamt_word(5'h05), OP_NONE);
        req(GRP_WORD_SHUFFLE, shamt_word(5'h0B), OP_WORD_BYTE_CONCAT);
        req(GRP_DWORD_SHUFFLE, shamt_word(5'h08), OP_DWORD_BYTE_CONCAT);
        req(GRP_WORD_SHUFFLE, shamt_word(5'h10), OP_SIGN_EXTEND_BYTE);
        req(GRP_WORD_SHUFFLE, shamt_word(5'h18), OP_SIGN_EXTEND_HALF);
        req(GRP_DWORD_SHUFFLE, shamt_word(5'h18), OP_NONE);
        req(GRP_DWORD_SHUFFLE, shamt_word(5'h11), OP_NONE);
        idle();
    endtask

    task automatic t_sysctl;
        logic [5:0] fn [9];
        fn = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h08, 6'h18, 6'h1F, 6'h20};
        for (int i = 0; i < 6; i++) begin
            req(GRP_SYSCTL, rsf(5'(i + (i > 2)), 6'h00), op_e'(OP_SYSCTL_MOVE_FROM + i));
        end
        req(GRP_SYSCTL, rsf(5'h0A, 6'h00), OP_PREV_SHADOW_READ);
        req(GRP_SYSCTL, rsf(5'h0E, 6'h00), OP_PREV_SHADOW_WRITE);
        req(GRP_SYSCTL, rsf(5'h0B, 6'h1F), OP_INTR_DISABLE);
        req(GRP_SYSCTL, rsf(5'h0B, 6'h20), OP_INTR_ENABLE);
        req(GRP_SYSCTL, rsf(5'h03, 6'h00), OP_NONE);
        // low source bits vary so values 16 to 24 with bit 25 set are exercised
        for (int i = 0; i < 9; i++) begin
            req(GRP_SYSCTL, rsf(5'(16 + i), fn[i]), op_e'(OP_TRANSLATION_ENTRY_READ + i));
        end
        req(GRP_SYSCTL, rsf(5'h1F, 6'h00), OP_NONE);
        idle();
    endtask

    task automatic t_pc_relative_group;
        req(GRP_PC_RELATIVE, pcr(5'h03), OP_PC_ADD_IMM);
        req(GRP_PC_RELATIVE, pcr(5'h0D), OP_PC_LOAD_WORD);
        req(GRP_PC_RELATIVE, pcr(5'h17), OP_PC_LOAD_WORD_UNSIGNED);
        req(GRP_PC_RELATIVE, pcr(5'h19), OP_PC_LOAD_DWORD);
        req(GRP_PC_RELATIVE, pcr(5'h1E), OP_PC_ADD_UPPER);
        req(GRP_PC_RELATIVE, pcr(5'h1F), OP_PC_ADD_UPPER_ALIGNED);
        req(GRP_PC_RELATIVE, pcr(5'h1C), OP_NONE);
        req(GRP_PC_RELATIVE, pcr(5'h1D), OP_NONE);
        idle();
    endtask

    task automatic t_fpu;
        for (int i = 0; i < 8; i++) begin
            req(GRP_FPU, rsf(5'(i), 6'h00), op_e'(OP_FPU_MOVE_FROM + i));
        end
        for (int i = 0; i < 5; i++) begin
            req(GRP_FPU, rsf(5'(16 + i + 2 * (i > 1)), 6'h15), op_e'(OP_FMT_SINGLE + i));
        end
        req(GRP_FPU, rsf(5'h09, 6'h00), OP_FPU_BRANCH_COND_ZERO);
        req(GRP_FPU, rsf(5'h0D, 6'h00), OP_FPU_BRANCH_COND_NONZERO);
        req(GRP_FPU, rsf(5'h0B, 6'h00), OP_VECTOR_BRANCH_ALL_ZERO);
        req(GRP_FPU, rsf(5'h0F, 6'h00), OP_VECTOR_BRANCH_ANY_NONZERO);
        req(GRP_FPU, rsf(5'h18, 6'h00), OP_VECTOR_ELEM_ZERO);
        req(GRP_FPU, rsf(5'h1F, 6'h00), OP_VECTOR_ELEM_NONZERO);
        req(GRP_FPU, rsf(5'h0C, 6'h00), OP_NONE);
        req(GRP_NONE, 32'h0000_0000, OP_NONE);
        idle();
    endtask

    // tallies first, then a request swallowed by a mid-run reset
    task automatic t_reset;
        cmp(taken, 16'(exp_taken));
        cmp(trapped, 16'(exp_trapped));
        instr_valid_in = 1'b1;
        reset_in       = 1'b1;
        @(posedge clk_in);
        #1;
        reset_in = 1'b0;
        idle();
        cmp(taken, 16'h0000);
        req(GRP_DWORD_SHIFT_RIGHT, 32'h0020_0000, OP_DWORD_ROTATE_RIGHT);
        idle();
    endtask

    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end

    initial begin
        errors             = 0;
        samples_checked    = 0;
        exp_taken          = 0;
        exp_trapped        = 0;
        reset_in           = 1'b1;
        instr_valid_in     = 1'b0;
        instr_in           = 32'h0000_0000;
        group_in           = GRP_NONE;
        compat_release1_in = 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
        reset_in = 1'b0;
        t_shift();
        t_shuffle();
        t_sysctl();
        t_pc_relative_group();
        t_fpu();
        t_reset();
        finish_test();
    end

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (2000) @(posedge clk_in);
        errors++;
        finish_test();
    end
endmodule
`default_nettype wire
